// >>> design/hpmb_mailbox.sv
module hpmb_mailbox
    import hpmb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // On-chip CPU access
    input wire hpmb_acc_t cpuAcc,
    output logic [15:0] cpuRdata,
    // External host access (memory cycles and status poll)
    input wire hpmb_acc_t hostAcc,
    input wire logic hostStatusRd,
    output logic [15:0] hostRdata,
    output logic [15:0] hostStatus,
    output logic hostPortIrq,
    // Memory-cycle marker towards the CPU side
    output logic hostMemCycle,
    // Mailbox interrupts and enables
    input wire logic rxFullEn,
    input wire logic txEmptyEn,
    output logic mailboxReceiveFullIrq,
    output logic mailboxTransmitEmptyIrq,
    // Engine events and unrouted copies for the CPU, SOF copies gated by routing bits 12 and 10
    input wire hpmb_events_t engEvents,
    output hpmb_events_t cpuEvents,
    // OTG pins
    input wire logic vbusValidPin,
    input wire logic idPin
);
    hpmb_state_t s_r;
    hpmb_state_t s_nxt;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic hit(input hpmb_acc_t a, input logic [15:0] adr, input logic isWr);
        hit = (isWr ? a.wr : a.rd) && (a.addr == adr);
    endfunction

    logic cpuWrMsg1, cpuWrMsg2, hostRdMsg1, hostRdMsg2;
    logic cpuWrMb, cpuRdMb, hostWrMb, hostRdMb;
    logic [15:0] routedVec;
    logic [15:0] statusVec;

    // Access strobes
    always_comb begin
        cpuWrMsg1 = hit(cpuAcc, ADDR_ENG1_MSG, 1'b1);
        cpuWrMsg2 = hit(cpuAcc, ADDR_ENG2_MSG, 1'b1);
        hostRdMsg1 = hit(hostAcc, ADDR_ENG1_MSG, 1'b0);
        hostRdMsg2 = hit(hostAcc, ADDR_ENG2_MSG, 1'b0);
        cpuWrMb = hit(cpuAcc, ADDR_MAILBOX, 1'b1);
        cpuRdMb = hit(cpuAcc, ADDR_MAILBOX, 1'b0);
        hostWrMb = hit(hostAcc, ADDR_MAILBOX, 1'b1);
        hostRdMb = hit(hostAcc, ADDR_MAILBOX, 1'b0);
    end

    // ****************************************
    // Event routing and status assembly
    // ****************************************
    always_comb begin
        routedVec = '0;
        routedVec[ST_SOF2] = engEvents.sofEop[1];
        routedVec[ST_SOF1] = engEvents.sofEop[0];
        routedVec[ST_RESET2] = engEvents.usbReset[1];
        routedVec[ST_RESET1] = engEvents.usbReset[0];
        routedVec[ST_RESUME2] = engEvents.resume[1];
        routedVec[ST_RESUME1] = engEvents.resume[0];
        routedVec[ST_DONE2] = engEvents.done[1];
        routedVec[ST_DONE1] = engEvents.done[0];
        // Routing bit positions match status positions except SOF, shifted by one
        routedVec[ST_SOF2] = routedVec[ST_SOF2] & s_r.routing[13];
        routedVec[ST_SOF1] = routedVec[ST_SOF1] & s_r.routing[11];
        routedVec[ST_RESET2] = routedVec[ST_RESET2] & s_r.routing[9];
        routedVec[ST_RESUME2] = routedVec[ST_RESUME2] & s_r.routing[7];
        routedVec[ST_RESUME1] = routedVec[ST_RESUME1] & s_r.routing[6];
        routedVec[ST_DONE2] = routedVec[ST_DONE2] & s_r.routing[3];
        routedVec[ST_DONE1] = routedVec[ST_DONE1] & s_r.routing[2];
        routedVec[ST_RESET1] = routedVec[ST_RESET1] & s_r.routing[1];
        statusVec = routedVec;
        statusVec[ST_VBUS] = s_r.vbusSync[1];
        statusVec[ST_ID] = s_r.idSync[1];
    end

    // Unrouted events stay with the CPU, except SOF, which routing bits 12 and 10 pass to the CPU
    always_comb begin
        cpuEvents.sofEop[1] = engEvents.sofEop[1] & s_r.routing[12];
        cpuEvents.sofEop[0] = engEvents.sofEop[0] & s_r.routing[10];
        cpuEvents.usbReset[1] = engEvents.usbReset[1] & ~s_r.routing[9];
        cpuEvents.usbReset[0] = engEvents.usbReset[0] & ~s_r.routing[1];
        cpuEvents.resume[1] = engEvents.resume[1] & ~s_r.routing[7];
        cpuEvents.resume[0] = engEvents.resume[0] & ~s_r.routing[6];
        cpuEvents.done[1] = engEvents.done[1] & ~s_r.routing[3];
        cpuEvents.done[0] = engEvents.done[0] & ~s_r.routing[2];
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        // Pin synchronisers
        s_nxt.vbusSync = {s_r.vbusSync[0], vbusValidPin};
        s_nxt.idSync = {s_r.idSync[0], idPin};
        // Message flags, set wins over clear
        if (hostRdMsg1) s_nxt.msgFlag[0] = 1'b0;
        if (hostRdMsg2) s_nxt.msgFlag[1] = 1'b0;
        if (cpuWrMsg1) s_nxt.msgFlag[0] = 1'b1;
        if (cpuWrMsg2) s_nxt.msgFlag[1] = 1'b1;
        // Routing register, host writable only
        if (hit(hostAcc, ADDR_ROUTING, 1'b1)) s_nxt.routing = hostAcc.wdata;
        // Mailbox data, host write after CPU write in same cycle
        if (cpuWrMb) s_nxt.mailbox = cpuAcc.wdata;
        if (hostWrMb) s_nxt.mailbox = hostAcc.wdata;
        // Incoming flag and receive-full irq
        if (cpuRdMb) begin
            s_nxt.mboxIn = 1'b0;
            s_nxt.rxFullIrq = 1'b0;
        end
        if (hostWrMb) s_nxt.mboxIn = 1'b1;
        if (hostWrMb && rxFullEn) s_nxt.rxFullIrq = 1'b1;
        // Outgoing flag and transmit-empty irq, set after clear so the event wins
        if (hostRdMb) s_nxt.mboxOut = 1'b0;
        if (cpuWrMb) begin
            s_nxt.mboxOut = 1'b1;
            s_nxt.txEmptyIrq = 1'b0;
        end
        if (hostRdMb && txEmptyEn) s_nxt.txEmptyIrq = 1'b1;
        // Read data, registered
        s_nxt.cpuRdata = cpuRdMb ? s_r.mailbox : 16'h0000;
        unique case (1'b1)
            hostRdMb: s_nxt.hostRdata = s_r.mailbox;
            hit(hostAcc, ADDR_ROUTING, 1'b0): s_nxt.hostRdata = s_r.routing;
            default: s_nxt.hostRdata = 16'h0000;
        endcase
        s_nxt.status = statusVec;
        // Flags join the status word in the same cycle as the flags themselves
        s_nxt.status[ST_MBOX_IN] = s_nxt.mboxIn;
        s_nxt.status[ST_MBOX_OUT] = s_nxt.mboxOut;
        s_nxt.status[ST_MSG2] = s_nxt.msgFlag[1];
        s_nxt.status[ST_MSG1] = s_nxt.msgFlag[0];
        s_nxt.hostIrq = (|s_nxt.msgFlag) | s_nxt.mboxOut | (|routedVec);
        if (reset) begin
            s_nxt = '0;
            s_nxt.mailbox = MAILBOX_RST;
            s_nxt.routing = ROUTING_RST;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cpuRdata = s_r.cpuRdata;
    assign hostRdata = s_r.hostRdata;
    assign hostStatus = s_r.status;
    assign hostPortIrq = s_r.hostIrq;
    assign hostMemCycle = (hostAcc.wr | hostAcc.rd) & ~hostStatusRd;
    assign mailboxReceiveFullIrq = s_r.rxFullIrq;
    assign mailboxTransmitEmptyIrq = s_r.txEmptyIrq;

    // ****************************************
    // Checks
    // ****************************************
    property p_msgset;
        @(posedge clk) disable iff (reset) cpuWrMsg1 |=> hostStatus[ST_MSG1] ##0 hostPortIrq;
    endproperty
    a_msgset: assert property (p_msgset) else $error("msg1 flag not set");

    property p_msgclr;
        @(posedge clk) disable iff (reset) (hostRdMsg2 && !cpuWrMsg2) |=> !hostStatus[ST_MSG2];
    endproperty
    a_msgclr: assert property (p_msgclr) else $error("msg2 flag not cleared");

    property p_mbdata;
        @(posedge clk) disable iff (reset) (hostWrMb ##1 cpuRdMb) |=> cpuRdata == $past(hostAcc.wdata, 2);
    endproperty
    a_mbdata: assert property (p_mbdata) else $error("mailbox data lost");

    property p_rxfull;
        @(posedge clk) disable iff (reset) (hostWrMb && rxFullEn) |=> mailboxReceiveFullIrq;
    endproperty
    a_rxfull: assert property (p_rxfull) else $error("rx full missing");

    property p_rxclr;
        @(posedge clk) disable iff (reset) (cpuRdMb && !hostWrMb) |=> !mailboxReceiveFullIrq && !s_r.mboxIn;
    endproperty
    a_rxclr: assert property (p_rxclr) else $error("rx full not cleared");

    property p_txempty;
        @(posedge clk) disable iff (reset) (hostRdMb && txEmptyEn && !cpuWrMb) |=> mailboxTransmitEmptyIrq;
    endproperty
    a_txempty: assert property (p_txempty) else $error("tx empty missing");

    property p_txclr;
        @(posedge clk) disable iff (reset) (cpuWrMb && !(hostRdMb && txEmptyEn))
            |=> !mailboxTransmitEmptyIrq ##0 hostStatus[ST_MBOX_OUT];
    endproperty
    a_txclr: assert property (p_txclr) else $error("tx empty not cleared");

    property p_vbus;
        @(posedge clk) disable iff (reset) vbusValidPin [*4] |=> hostStatus[ST_VBUS];
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus flag wrong");

    property p_route;
        @(posedge clk) disable iff (reset) !s_r.routing[3] |=> !hostStatus[ST_DONE2];
    endproperty
    a_route: assert property (p_route) else $error("unrouted event shown");

    property p_msg2set;
        @(posedge clk) disable iff (reset) cpuWrMsg2 |=> hostStatus[ST_MSG2] ##0 hostPortIrq;
    endproperty
    a_msg2set: assert property (p_msg2set) else $error("msg2 flag not set");

    property p_msg1clr;
        @(posedge clk) disable iff (reset) (hostRdMsg1 && !cpuWrMsg1) |=> !hostStatus[ST_MSG1];
    endproperty
    a_msg1clr: assert property (p_msg1clr) else $error("msg1 flag not cleared");

    property p_mbirq;
        @(posedge clk) disable iff (reset) cpuWrMb |=> hostPortIrq;
    endproperty
    a_mbirq: assert property (p_mbirq) else $error("mailbox host irq missing");

    property p_mboutclr;
        @(posedge clk) disable iff (reset) (hostRdMb && !cpuWrMb) |=> !hostStatus[ST_MBOX_OUT];
    endproperty
    a_mboutclr: assert property (p_mboutclr) else $error("outgoing flag not cleared");

    property p_cpuzero;
        @(posedge clk) disable iff (reset) !cpuRdMb |=> cpuRdata == 16'h0000;
    endproperty
    a_cpuzero: assert property (p_cpuzero) else $error("cpu read data leaked");

    property p_pollfree;
        @(posedge clk) disable iff (reset) hostStatusRd |-> !hostMemCycle;
    endproperty
    a_pollfree: assert property (p_pollfree) else $error("status poll made memory cycle");

    property p_mbinset;
        @(posedge clk) disable iff (reset) hostWrMb |=> hostStatus[ST_MBOX_IN];
    endproperty
    a_mbinset: assert property (p_mbinset) else $error("incoming flag not set");

    property p_mboutset;
        @(posedge clk) disable iff (reset) cpuWrMb |=> hostStatus[ST_MBOX_OUT];
    endproperty
    a_mboutset: assert property (p_mboutset) else $error("outgoing flag not set");

    property p_vbuslow;
        @(posedge clk) disable iff (reset) !vbusValidPin [*4] |=> !hostStatus[ST_VBUS];
    endproperty
    a_vbuslow: assert property (p_vbuslow) else $error("vbus flag stuck high");

    property p_idhigh;
        @(posedge clk) disable iff (reset) idPin [*4] |=> hostStatus[ST_ID];
    endproperty
    a_idhigh: assert property (p_idhigh) else $error("id flag stuck low");

    property p_idlow;
        @(posedge clk) disable iff (reset) !idPin [*4] |=> !hostStatus[ST_ID];
    endproperty
    a_idlow: assert property (p_idlow) else $error("id flag stuck high");

    property p_sof1;
        @(posedge clk) disable iff (reset) (engEvents.sofEop[0] && s_r.routing[11]) |=> hostStatus[ST_SOF1];
    endproperty
    a_sof1: assert property (p_sof1) else $error("sof1 flag missing");

    property p_reset2;
        @(posedge clk) disable iff (reset) (engEvents.usbReset[1] && s_r.routing[9]) |=> hostStatus[ST_RESET2];
    endproperty
    a_reset2: assert property (p_reset2) else $error("reset2 flag missing");

    property p_resume2;
        @(posedge clk) disable iff (reset) (engEvents.resume[1] && s_r.routing[7]) |=> hostStatus[ST_RESUME2];
    endproperty
    a_resume2: assert property (p_resume2) else $error("resume2 flag missing");

    property p_done1;
        @(posedge clk) disable iff (reset) (engEvents.done[0] && s_r.routing[2]) |=> hostStatus[ST_DONE1];
    endproperty
    a_done1: assert property (p_done1) else $error("engine1_done_flag missing");

    property p_cpuev;
        @(posedge clk) disable iff (reset) s_r.routing[2] |-> !cpuEvents.done[0];
    endproperty
    a_cpuev: assert property (p_cpuev) else $error("routed event left at cpu");

    property p_irqor;
        @(posedge clk) disable iff (reset)
            (hostStatus[ST_SOF2] || hostStatus[ST_SOF1] || hostStatus[ST_MSG1]) |-> hostPortIrq;
    endproperty
    a_irqor: assert property (p_irqor) else $error("host irq misses a source");
endmodule // hpmb_mailbox

// >>> design/hpmb_pkg.sv
package hpmb_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [15:0] ADDR_ENG1_MSG = 16'h0144;
    localparam logic [15:0] ADDR_ENG2_MSG = 16'h0148;
    localparam logic [15:0] ADDR_ROUTING = 16'h0142;
    localparam logic [15:0] ADDR_MAILBOX = 16'hc0c6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] MAILBOX_RST = 16'h0000;
    localparam logic [15:0] ROUTING_RST = 16'h1400;

    // ****************************************
    // Status port bit positions
    // ****************************************
    localparam int ST_MBOX_OUT = 0;
    localparam int ST_RESET1 = 1;
    localparam int ST_DONE1 = 2;
    localparam int ST_DONE2 = 3;
    localparam int ST_MSG1 = 4;
    localparam int ST_MSG2 = 5;
    localparam int ST_RESUME1 = 6;
    localparam int ST_RESUME2 = 7;
    localparam int ST_MBOX_IN = 8;
    localparam int ST_RESET2 = 9;
    localparam int ST_SOF1 = 10;
    localparam int ST_SOF2 = 12;
    localparam int ST_ID = 14;
    localparam int ST_VBUS = 15;

    // Routing bits that gate engine events
    localparam logic [15:0] ROUTE_EVENT_MASK = 16'h2ace;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } hpmb_acc_t;

    // Engine event levels, one per engine
    typedef struct packed {
        logic [1:0] sofEop;
        logic [1:0] usbReset;
        logic [1:0] resume;
        logic [1:0] done;
    } hpmb_events_t;

    typedef struct packed {
        logic [15:0] mailbox;
        logic [15:0] routing;
        logic [1:0] msgFlag;
        logic mboxIn;
        logic mboxOut;
        logic rxFullIrq;
        logic txEmptyIrq;
        logic [15:0] cpuRdata;
        logic [15:0] hostRdata;
        logic [15:0] status;
        logic hostIrq;
        logic [1:0] vbusSync;
        logic [1:0] idSync;
    } hpmb_state_t;
endpackage

// >>> verification/hpmb_host_model.sv
module hpmb_host_model
    import hpmb_pkg::*;
#(
    parameter int VBUS_WAIT = 500
)
(
    // Clock
    input wire logic clk,
    // Host port requests
    output hpmb_acc_t hostAcc,
    output logic hostStatusRd,
    // Host port answers
    input wire logic [15:0] hostRdata,
    input wire logic hostMemCycle
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        hostAcc = '0;
        hostStatusRd = 1'b0;
    end

    // One memory cycle; released lines show no stale value
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                          output logic [15:0] rdata);
        @(posedge clk);
        hostAcc <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge clk);
        hostAcc <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        #1 rdata = hostRdata;
    endtask

    // Status poll riding on a read request
    task automatic poll(input logic [15:0] addr, output logic seen);
        @(posedge clk);
        hostStatusRd <= 1'b1;
        hostAcc <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        #1 seen = hostMemCycle;
        @(posedge clk);
        hostStatusRd <= 1'b0;
        hostAcc <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'hffff};
        #1;
    endtask

    // Supply settle before the flag is trusted
    task automatic vbusSettle();
        repeat (VBUS_WAIT) @(posedge clk);
        #1;
    endtask
endmodule // hpmb_host_model

// >>> verification/hpmb_mailbox_tb.sv
module hpmb_mailbox_tb
    import hpmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset, hostStatusRd, hostPortIrq, hostMemCycle, rxFullEn, txEmptyEn;
    logic rxIrq, txIrq, vbusValidPin, idPin, seen;
    hpmb_acc_t cpuAcc, hostAcc;
    hpmb_events_t engEvents, cpuEvents;
    logic [15:0] cpuRdata, hostRdata, hostStatus, d;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    hpmb_mailbox dut (.clk(clk), .reset(reset), .cpuAcc(cpuAcc), .cpuRdata(cpuRdata), .hostAcc(hostAcc),
        .hostStatusRd(hostStatusRd), .hostRdata(hostRdata), .hostStatus(hostStatus), .hostPortIrq(hostPortIrq),
        .hostMemCycle(hostMemCycle), .rxFullEn(rxFullEn), .txEmptyEn(txEmptyEn), .mailboxReceiveFullIrq(rxIrq),
        .mailboxTransmitEmptyIrq(txIrq), .engEvents(engEvents), .cpuEvents(cpuEvents),
        .vbusValidPin(vbusValidPin), .idPin(idPin));
    hpmb_host_model host (.clk(clk), .hostAcc(hostAcc), .hostStatusRd(hostStatusRd), .hostRdata(hostRdata),
        .hostMemCycle(hostMemCycle));

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cpuAccess(input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
        @(posedge clk);
        cpuAcc <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge clk);
        cpuAcc <= '0;
        #1 d = cpuRdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset <= 1'b1;
        cpuAcc <= '0;
        rxFullEn <= 1'b1;
        txEmptyEn <= 1'b1;
        engEvents <= '0;
        vbusValidPin <= 1'b0;
        idPin <= 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        cpuAccess(1'b0, ADDR_MAILBOX, 16'h0000);
        chk(d, MAILBOX_RST);
        settle(3);
        chk(hostStatus, 16'h0000);
        $display("test reset done");
        // Two messages back to back, cleared one at a time
        cpuAccess(1'b1, ADDR_ENG1_MSG, 16'h0000);
        cpuAccess(1'b1, ADDR_ENG2_MSG, 16'hffff);
        settle(3);
        chk(hostStatus, 16'h0030);
        chk({15'h0000, hostPortIrq}, 16'h0001);
        host.access(1'b0, ADDR_ENG1_MSG, 16'h0000, d);
        settle(3);
        chk(hostStatus, 16'h0020);
        chk({15'h0000, hostPortIrq}, 16'h0001);
        host.access(1'b0, ADDR_ENG2_MSG, 16'h0000, d);
        settle(3);
        chk({hostStatus[15:1], hostPortIrq}, 16'h0000);
        $display("test messages done");
        // Mailbox from CPU to host
        cpuAccess(1'b1, ADDR_MAILBOX, 16'ha5c3);
        settle(3);
        chk({hostStatus[15:1], hostPortIrq}, 16'h0001);
        chk(hostStatus, 16'h0001);
        host.access(1'b0, ADDR_MAILBOX, 16'h0000, d);
        chk(d, 16'ha5c3);
        settle(3);
        chk({hostStatus[15:1], hostPortIrq}, 16'h0000);
        chk({15'h0000, txIrq}, 16'h0001);
        cpuAccess(1'b1, ADDR_MAILBOX, 16'h5a3c);
        settle(3);
        chk({15'h0000, txIrq}, 16'h0000);
        txEmptyEn <= 1'b0;
        host.access(1'b0, ADDR_MAILBOX, 16'h0000, d);
        settle(3);
        chk({15'h0000, txIrq}, 16'h0000);
        $display("test outgoing done");
        // Mailbox from host to CPU
        host.access(1'b1, ADDR_MAILBOX, 16'h1e2d, d);
        settle(3);
        chk({14'h0000, hostStatus[8], rxIrq}, 16'h0003);
        cpuAccess(1'b0, ADDR_MAILBOX, 16'h0000);
        chk(d, 16'h1e2d);
        settle(3);
        chk({14'h0000, hostStatus[8], rxIrq}, 16'h0000);
        rxFullEn <= 1'b0;
        host.access(1'b1, ADDR_MAILBOX, 16'h0f0f, d);
        settle(3);
        chk({14'h0000, hostStatus[8], rxIrq}, 16'h0002);
        cpuAccess(1'b0, ADDR_MAILBOX, 16'h0000);
        // Host write and CPU read in adjacent cycles
        fork
            host.access(1'b1, ADDR_MAILBOX, 16'h3c4b, d);
            begin
                @(posedge clk);
                cpuAccess(1'b0, ADDR_MAILBOX, 16'h0000);
            end
        join
        chk(d, 16'h3c4b);
        $display("test incoming done");
        // Status port and event routing
        cpuAccess(1'b0, ADDR_ROUTING, 16'h0000);
        chk(d, 16'h0000);
        host.poll(ADDR_ROUTING, seen);
        chk({15'h0000, seen}, 16'h0000);
        engEvents <= '1;
        settle(3);
        chk({hostStatus[14:0], hostPortIrq} & 16'h2d9d, 16'h0000);
        chk({8'h00, cpuEvents}, 16'h00ff);
        host.access(1'b1, ADDR_ROUTING, ROUTE_EVENT_MASK, d);
        settle(3);
        chk(hostStatus & 16'h1400, 16'h1400);
        chk(hostStatus & 16'h0202, 16'h0202);
        chk(hostStatus & 16'h00c0, 16'h00c0);
        chk(hostStatus & 16'h000c, 16'h000c);
        chk({7'h00, cpuEvents, hostPortIrq}, 16'h0001);
        // Only the engine 1 frame event, routed: it alone must raise the host pin
        engEvents <= '{sofEop: 2'b01, usbReset: 2'b00, resume: 2'b00, done: 2'b00};
        settle(3);
        chk({12'h000, hostStatus[12:10], hostPortIrq}, 16'h0003);
        engEvents <= '0;
        $display("test routing done");
        // Supply and identity pins
        vbusValidPin <= 1'b1;
        host.vbusSettle();
        chk({14'h0000, hostStatus[15:14]}, 16'h0002);
        vbusValidPin <= 1'b0;
        idPin <= 1'b1;
        settle(4);
        chk({14'h0000, hostStatus[15:14]}, 16'h0001);
        $display("test pins done");
        print_verdict();
    end
endmodule // hpmb_mailbox_tb
